// [uam_core.sv]
// async serial engine, 8-bit and 9-bit framing, with register port
// Notes on behaviour
// - mode 1 buffer write loads marker one at ninth bit, sets pending
// - transmission starts after next divide-by-16 rollover
// - start bit first, data one bit later, first shift one bit after
// - shift right with zeros; end pattern gives last shift, done at 10th
// - modes 2/3 load ninth bit value; first shift inserts stop one
// - modes 2/3 last shift clears active and sets done at 11th rollover
// - mode 2 tick from oscillator /2 or /4, bits /32 or /64; mode 3 from timers
// - receiver samples at sixteen times baud, starts on falling edge
// - falling edge restarts divide-by-16 counter at one, fills shifter with ones
// - each bit sampled at states seven, eight, nine; majority accepted
// - nonzero first bit is a false start; go back to hunting
// - bits enter from right; start bit leftmost gives final shift, load
// - mode 1 loads only if flag clear and filter off or stop one
// - mode 1 load stores stop bit, eight data bits, sets receive flag
// - modes 2/3 load if flag clear and filter off or ninth one
// - mode 1 returns to edge hunting right after final shift
// - modes 2/3 resume hunting one bit time after final shift
`timescale 1ns/100ps

module uam_core
(
    input  wire logic                       clk,
    input  wire logic                       rst_n,
    input  wire logic                       ce,
    input  wire logic [uam_pkg::ADDR_W-1:0] regAddr,
    input  wire logic [uam_pkg::DATA_W-1:0] regWdata,
    input  wire logic                       regWr,
    input  wire logic                       regRd,
    output logic      [uam_pkg::DATA_W-1:0] regRdata,
    input  wire logic                       timer1Roll,
    input  wire logic                       timer2Roll,
    input  wire logic                       rxPin,
    output logic                            txPin,
    output logic                            irq
);
    import uam_pkg::*;

    // ************************************************************
    // declarations
    // ************************************************************
    logic [CTRL_W-1:0] ctrl;
    logic [EVT_W-1:0]  intEn;
    logic [1:0]        mode;
    logic              multiproc_filter_en;
    logic              tx_ninth_bit;
    logic              rx_ninth_bit;
    logic              rx_frame_flag;
    logic              tx_done_flag;
    logic [7:0]        serial_buffer_reg;
    logic [1:0]        preDiv;
    logic              tick;
    logic [3:0]        txDiv;
    logic              txRoll;
    uam_tx_t           txState;
    logic [8:0]        txShift;
    logic              txFirst;
    logic              txEnd;
    logic              next_txPin;
    logic              rxMeta;
    logic              rxSync;
    logic              rxPrev;
    uam_rx_t           rxState;
    logic [3:0]        rxDiv;
    logic [8:0]        rxShift;
    logic              sampA;
    logic              sampB;
    logic              bitVal;
    logic              rxFinal;
    logic              rxLoad;
    logic              wrData;
    logic              wrClr;
    logic              txSet;
    logic [DATA_W-1:0] next_rdata;

    // two-of-three vote on bit samples
    function automatic logic vote(input logic a,
                                  input logic b,
                                  input logic c);
        vote = (a & b) | (a & c) | (b & c);
    endfunction : vote

    // ************************************************************
    // register port
    // ************************************************************
    assign mode                = ctrl[CTRL_MODE_HI:CTRL_MODE_LO];
    assign multiproc_filter_en = ctrl[CTRL_MPF];
    assign tx_ninth_bit        = ctrl[CTRL_TX9];
    assign wrData = regWr && (regAddr == OFS_DATA);
    assign wrClr  = regWr && (regAddr == OFS_INT_CLR);

    // control register
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            ctrl <= CTRL_RST;
        else if (ce && regWr && regAddr == OFS_CTRL)
            ctrl <= regWdata[CTRL_W-1:0];
    end

    // interrupt enable register
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            intEn <= INT_EN_RST;
        else if (ce && regWr && regAddr == OFS_INT_EN)
            intEn <= regWdata[EVT_W-1:0];
    end

    // read data mux, unmapped reads give zero
    always_comb
    begin
        next_rdata = '0;
        case (regAddr)
            OFS_CTRL:
                next_rdata = {1'b0, ctrl};
            OFS_DATA:
                next_rdata = serial_buffer_reg;
            OFS_STATUS:
            begin
                next_rdata[ST_RXF]    = rx_frame_flag;
                next_rdata[ST_TXD]    = tx_done_flag;
                next_rdata[ST_RX9]    = rx_ninth_bit;
                next_rdata[ST_TXBUSY] = (txState != TX_IDLE);
                next_rdata[ST_RXBUSY] = (rxState != RX_HUNT);
            end
            OFS_INT_EN:
                next_rdata = {6'h00, intEn};
            default:
                next_rdata = '0;
        endcase
    end

    // read data stands in the cycle after the strobe only
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            regRdata <= '0;
        else if (ce)
            regRdata <= regRd ? next_rdata : '0;
    end

    // level interrupt from enabled sticky bits
    assign irq = |({tx_done_flag, rx_frame_flag} & intEn);

    // ************************************************************
    // baud tick
    // ************************************************************
    // mode 2 divides the clock, modes 1/3 take timer rollovers
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            preDiv <= 2'h0;
        else if (ce)
        begin
            if (tick || mode != MODE_2)
                preDiv <= 2'h0;
            else
                preDiv <= preDiv + 2'h1;
        end
    end

    always_comb
    begin
        tick = 1'b0;
        case (mode)
            MODE_2:
                tick = (preDiv == (ctrl[CTRL_FAST] ?
                        M2_DIV_FAST : M2_DIV_SLOW));
            MODE_1, MODE_3:
                tick = ctrl[CTRL_TSEL] ? timer2Roll
                                       : timer1Roll;
            default:
                tick = 1'b0;
        endcase
    end

    // ************************************************************
    // transmitter
    // ************************************************************
    // free running divide-by-16 for bit timing
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            txDiv <= 4'h0;
        else if (ce && tick)
            txDiv <= txDiv + 4'h1;
    end

    assign txRoll = tick && (txDiv == DIV_LAST);
    // end pattern: marker or stop just left of output bit
    assign txEnd  = !txFirst && (txShift[8:1] == TX_END_PAT);

    // transmit sequencer
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            txState <= TX_IDLE;
            txShift <= 9'h000;
            txFirst <= 1'b0;
        end
        else if (ce)
        begin
            case (txState)
                TX_IDLE:
                    if (wrData)
                    begin
                        if (mode == MODE_1)
                            txShift <= {1'b1, regWdata};
                        else
                            txShift <= {tx_ninth_bit,
                                        regWdata};
                        txFirst <= 1'b1;
                        txState <= TX_WAIT;
                    end
                TX_WAIT:
                    if (txRoll)
                        txState <= TX_START;
                TX_START:
                    if (txRoll)
                        txState <= TX_DATA;
                TX_DATA:
                    if (txRoll)
                    begin
                        if (txEnd)
                        begin
                            txShift <= {1'b0, txShift[8:1]};
                            txState <= TX_IDLE;
                        end
                        else if (txFirst && mode != MODE_1)
                            txShift <= {1'b1, txShift[8:1]};
                        else
                            txShift <= {1'b0, txShift[8:1]};
                        txFirst <= 1'b0;
                    end
                default:
                    txState <= TX_IDLE;
            endcase
        end
    end

    assign txSet = txRoll && (txState == TX_DATA) && txEnd;

    // done flag, a set in the clear cycle wins
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            tx_done_flag <= 1'b0;
        else if (ce)
        begin
            if (txSet)
                tx_done_flag <= 1'b1;
            else if (wrClr && regWdata[ST_TXD])
                tx_done_flag <= 1'b0;
        end
    end

    // pin level per phase, high when idle
    always_comb
    begin
        case (txState)
            TX_START:
                next_txPin = 1'b0;
            TX_DATA:
                next_txPin = txShift[0];
            default:
                next_txPin = 1'b1;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            txPin <= 1'b1;
        else if (ce)
            txPin <= next_txPin;
    end

    // ************************************************************
    // receiver
    // ************************************************************
    // pin synchroniser and edge history
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rxMeta <= 1'b1;
            rxSync <= 1'b1;
            rxPrev <= 1'b1;
        end
        else if (ce)
        begin
            rxMeta <= rxPin;
            rxSync <= rxMeta;
            if (tick)
                rxPrev <= rxSync;
        end
    end

    // majority and final shift decode at third sample
    assign bitVal  = vote(sampA, sampB, rxSync);
    assign rxFinal = !rxShift[8];
    assign rxLoad  = tick && (rxState == RX_BITS) &&
                     (rxDiv == SAMP_C) && rxShift != RX_ALL_ONES &&
                     rxFinal && !rx_frame_flag &&
                     (!multiproc_filter_en || bitVal);

    // receive sequencer
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rxState <= RX_HUNT;
            rxDiv   <= 4'h0;
            rxShift <= RX_ALL_ONES;
            sampA   <= 1'b1;
            sampB   <= 1'b1;
        end
        else if (ce && tick)
        begin
            rxDiv <= rxDiv + 4'h1;
            case (rxState)
                RX_HUNT:
                    if (ctrl[CTRL_RXEN] && rxPrev && !rxSync)
                    begin
                        rxDiv   <= 4'h1;
                        rxShift <= RX_ALL_ONES;
                        rxState <= RX_BITS;
                    end
                RX_BITS:
                begin
                    if (rxDiv == SAMP_A)
                        sampA <= rxSync;
                    if (rxDiv == SAMP_B)
                        sampB <= rxSync;
                    if (rxDiv == SAMP_C)
                    begin
                        rxShift <= {rxShift[7:0], bitVal};
                        if (rxShift == RX_ALL_ONES && bitVal)
                            rxState <= RX_HUNT;
                        else if (rxShift != RX_ALL_ONES && rxFinal)
                        begin
                            if (mode == MODE_1)
                                rxState <= RX_HUNT;
                            else
                                rxState <= RX_TAIL;
                        end
                    end
                end
                RX_TAIL:
                    if (rxDiv == SAMP_C)
                        rxState <= RX_HUNT;
                default:
                    rxState <= RX_HUNT;
            endcase
        end
    end

    // buffer load, data bits arrive least significant first
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            serial_buffer_reg <= 8'h00;
            rx_ninth_bit      <= 1'b0;
        end
        else if (ce && rxLoad)
        begin
            serial_buffer_reg <= {rxShift[0], rxShift[1],
                                  rxShift[2], rxShift[3],
                                  rxShift[4], rxShift[5],
                                  rxShift[6], rxShift[7]};
            rx_ninth_bit      <= bitVal;
        end
    end

    // receive flag, a set in the clear cycle wins
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            rx_frame_flag <= 1'b0;
        else if (ce)
        begin
            if (rxLoad)
                rx_frame_flag <= 1'b1;
            else if (wrClr && regWdata[ST_RXF])
                rx_frame_flag <= 1'b0;
        end
    end

endmodule : uam_core

// [uam_pkg.sv]
// constants, offsets and state types for the async serial engine
package uam_pkg;

    // ************************************************************
    // bus geometry
    // ************************************************************
    localparam int ADDR_W = 3;
    localparam int DATA_W = 8;

    // ************************************************************
    // register offsets
    // ************************************************************
    localparam logic [2:0] OFS_CTRL   = 3'h0;
    localparam logic [2:0] OFS_DATA   = 3'h1;
    localparam logic [2:0] OFS_STATUS = 3'h2;
    localparam logic [2:0] OFS_INT_EN = 3'h3;
    localparam logic [2:0] OFS_INT_CLR = 3'h4;

    // ************************************************************
    // control field positions
    // ************************************************************
    localparam int CTRL_MODE_LO  = 0;
    localparam int CTRL_MODE_HI  = 1;
    localparam int CTRL_MPF      = 2;
    localparam int CTRL_TX9      = 3;
    localparam int CTRL_FAST     = 4;
    localparam int CTRL_TSEL     = 5;
    localparam int CTRL_RXEN     = 6;
    localparam int CTRL_W        = 7;

    // ************************************************************
    // status field positions
    // ************************************************************
    localparam int ST_RXF    = 0;
    localparam int ST_TXD    = 1;
    localparam int ST_RX9    = 2;
    localparam int ST_TXBUSY = 3;
    localparam int ST_RXBUSY = 4;
    localparam int EVT_W     = 2;

    // ************************************************************
    // reset values and codes
    // ************************************************************
    localparam logic [6:0] CTRL_RST   = 7'h00;
    localparam logic [1:0] INT_EN_RST = 2'h0;
    localparam logic [1:0] MODE_1     = 2'h1;
    localparam logic [1:0] MODE_2     = 2'h2;
    localparam logic [1:0] MODE_3     = 2'h3;

    // ************************************************************
    // timing counts
    // ************************************************************
    localparam logic [1:0] M2_DIV_FAST = 2'h1; // tick every 2 clocks
    localparam logic [1:0] M2_DIV_SLOW = 2'h3; // tick every 4 clocks
    localparam logic [3:0] DIV_LAST    = 4'hF;
    localparam logic [3:0] SAMP_A      = 4'h7;
    localparam logic [3:0] SAMP_B      = 4'h8;
    localparam logic [3:0] SAMP_C      = 4'h9;
    localparam logic [8:0] RX_ALL_ONES = 9'h1FF;
    localparam logic [7:0] TX_END_PAT  = 8'h01;

    // ************************************************************
    // state types
    // ************************************************************
    typedef enum logic [1:0] {
        TX_IDLE, TX_WAIT, TX_START, TX_DATA
    } uam_tx_t;

    typedef enum logic [1:0] {
        RX_HUNT, RX_BITS, RX_TAIL
    } uam_rx_t;

endpackage : uam_pkg

// [uam_core_properties.sv]
// concurrent checks on the serial engine ports, bound to its top
`timescale 1ns/100ps
module uam_core_properties
(
    input wire logic                       clk,
    input wire logic                       rst_n,
    input wire logic                       ce,
    input wire logic [uam_pkg::ADDR_W-1:0] regAddr,
    input wire logic [uam_pkg::DATA_W-1:0] regWdata,
    input wire logic                       regWr,
    input wire logic                       regRd,
    input wire logic [uam_pkg::DATA_W-1:0] regRdata,
    input wire logic                       timer1Roll,
    input wire logic                       timer2Roll,
    input wire logic                       rxPin,
    input wire logic                       txPin,
    input wire logic                       irq
);
    import uam_pkg::*;
    // ****************************************************************
    // helper state
    // ****************************************************************
    logic [7:0] ctrl;   // shadow of control writes
    logic [1:0] intEn;  // shadow of enable writes
    logic [9:0] lowLen; // clocks the output has stayed low
    logic       fast2;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // shadows of the software-written registers
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctrl  <= 8'h00;
            intEn <= 2'h0;
        end
        else if (ce && regWr && regAddr == OFS_CTRL)
            ctrl <= regWdata;
        else if (ce && regWr && regAddr == OFS_INT_EN)
            intEn <= regWdata[1:0];
    end
    // length of the current low run on the serial output
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            lowLen <= 10'h000;
        else
            lowLen <= txPin ? 10'h000 : lowLen + 10'h001;
    end
    assign fast2 = ctrl[1:0] == MODE_2 && ctrl[CTRL_FAST];
    // ****************************************************************
    // assertions
    // ****************************************************************
    a_rdata_idle_zero: assert property (!regRd |=> regRdata == 8'h00)
        else $error("read data not zero outside a read");
    a_clr_reads_zero: assert property (regRd && (regAddr == OFS_INT_CLR
        || regAddr > 3'h4) |=> regRdata == 8'h00)
        else $error("clear or unmapped place read not zero");
    a_ctrl_readback: assert property (regRd && regAddr == OFS_CTRL
        |=> regRdata == {1'h0, ctrl[6:0]})
        else $error("control readback differs from last write");
    a_irq_needs_enable: assert property (irq |-> intEn != 2'h0)
        else $error("interrupt with all sources masked");
    a_irq_matches_status: assert property (regRd && regAddr == OFS_STATUS
        |=> $past(irq) == ((regRdata[ST_RXF] && intEn[0])
        || (regRdata[ST_TXD] && intEn[1])))
        else $error("interrupt line disagrees with status");
    a_tx_bit_len: assert property ($rose(txPin) && fast2 |->
        lowLen[4:0] == 5'h00 && lowLen != 10'h000)
        else $error("low run not a whole number of bit times");
    a_tx_start_bound: assert property (regWr && regAddr == OFS_DATA
        && fast2 |-> ##[1:38] !txPin)
        else $error("start bit late after buffer write");
    a_reset_idle: assert property ($rose(rst_n) |->
        txPin && !irq && regRdata == 8'h00)
        else $error("outputs not idle after reset");
    c_data_write: cover property (regWr && regAddr == OFS_DATA);
    c_irq_rise: cover property ($rose(irq));
    c_fast_bit: cover property ($rose(txPin) && fast2);
endmodule : uam_core_properties

bind uam_core uam_core_properties i_uam_core_properties (.clk, .rst_n,
    .ce, .regAddr, .regWdata, .regWr, .regRd, .regRdata, .timer1Roll,
    .timer2Roll, .rxPin, .txPin, .irq);

// [uam_partner.sv]
// far-side serial model: sends frames to the receiver, decodes output
`timescale 1ns/100ps
module uam_partner
(
    input  wire logic       clk,
    input  wire logic       txPin,
    input  wire logic [7:0] bitClks,
    input  wire logic       nineBit,
    output logic            rxPin
);
    // ****************************************************************
    // frame send and decode
    // ****************************************************************
    logic [9:0] gotQ[$]; // decoded frames, stop bit above the data
    initial rxPin = 1'h1; // line idles high
    // send n bits of f, bit 0 first, each held len clocks
    task automatic send(input logic [10:0] f, input int n, input int len);
        for (int i = 0; i < n; i++)
        begin
            rxPin <= f[i];
            repeat (len) @(posedge clk);
        end
        rxPin <= 1'h1; // back to idle high
    endtask : send
    // decode one frame from its falling start edge, sampling mid-bit
    always
    begin : decode
        logic [9:0] v;
        @(negedge txPin);
        v = 10'h000;
        repeat (bitClks / 2) @(posedge clk);
        for (int i = 0; i < (nineBit ? 10 : 9); i++)
        begin
            repeat (bitClks) @(posedge clk);
            v[i] = txPin;
        end
        gotQ.push_back(v);
    end
endmodule : uam_partner

// [uam_core_tb.sv]
// self-checking bench: registers, transmit and receive in every mode
`timescale 1ns/100ps
module uam_core_tb;
    import uam_pkg::*;
    // ****************************************************************
    // signals and model state
    // ****************************************************************
    localparam int LIMIT = 40000; // tests need about 11000 cycles
    logic        clk, rst_n, ce, regWr, regRd, timer1Roll, timer2Roll;
    logic        txPin, rxPin, irq, nine;
    logic [2:0]  regAddr;
    logic [7:0]  regWdata, regRdata, bc, c, d, s;
    logic [31:0] seed;
    logic [9:0]  txQ[$]; // frames the transmitter owes the partner
    logic [7:0]  cfgs[4] = '{8'h41, 8'h63, 8'h52, 8'h42};
    int          fails, checksDone, cyc, el, mpf;
    int          expFlag, expDone, expNinth, expByte, expEn;
    time         t0;

    uam_core i_uam_core (.clk, .rst_n, .ce, .regAddr, .regWdata, .regWr,
        .regRd, .regRdata, .timer1Roll, .timer2Roll, .rxPin, .txPin, .irq);
    uam_partner i_uam_partner (.clk, .txPin, .bitClks(bc), .nineBit(nine),
        .rxPin);
    // free-running clock, 50 ns period
    initial
    begin
        clk = 1'h0;
        forever #25 clk = ~clk;
    end
    // timer 1 rolls every second clock, timer 2 every fourth; hang ceiling
    always @(posedge clk)
    begin
        timer1Roll <= ~timer1Roll;
        timer2Roll <= (cyc % 4) == 0;
        cyc <= cyc + 1;
        if (cyc == LIMIT)
        begin
            fails++;
            closeOut();
        end
    end
    // ****************************************************************
    // tasks
    // ****************************************************************
    task automatic chk(input logic [9:0] got, input logic [9:0] exp);
        checksDone++;
        if (got !== exp)
        begin
            fails++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [2:0] a, input logic [7:0] v);
        @(posedge clk);
        regAddr  <= a;
        regWdata <= v;
        regWr    <= 1'h1;
        @(posedge clk);
        regWr    <= 1'h0;
    endtask : wr
    task automatic rd(input logic [2:0] a, output logic [7:0] v);
        @(posedge clk);
        regAddr <= a;
        regRd   <= 1'h1;
        @(posedge clk);
        regRd   <= 1'h0;
        #1 v = regRdata;
    endtask : rd
    function automatic logic [31:0] xs(input logic [31:0] v);
        logic [31:0] x;
        x = v ^ (v << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs
    // status flags and interrupt line against the model
    task automatic chkStatus;
        logic [7:0] v;
        rd(OFS_STATUS, v);
        chk(10'(v & 8'h07), 10'(expNinth * 4 + expDone * 2 + expFlag));
        chk(10'(irq), 10'((expFlag & expEn) | (expDone & (expEn >> 1))));
    endtask : chkStatus
    // one frame from the partner, then model update and compare
    task automatic rxFrame(input logic [7:0] dv, input logic lb);
        logic [7:0] v;
        i_uam_partner.send({1'h1, lb, dv, 1'h0}, nine ? 11 : 10, bc);
        if (expFlag == 0 && (mpf == 0 || lb))
        begin
            expFlag = 1;
            expByte = dv;
            expNinth = lb;
        end
        chkStatus();
        rd(OFS_DATA, v);
        chk(10'(v), 10'(expByte));
    endtask : rxFrame
    task automatic runMode(input int k);
        c = cfgs[k];
        bc = (k % 2 == 1) ? 8'h40 : 8'h20;
        nine = c[1:0] != MODE_1;
        seed = xs(seed);
        c[CTRL_TX9] = seed[8];
        mpf = 0;
        wr(OFS_CTRL, c);
        rd(OFS_CTRL, d);
        chk(10'(d), 10'(c));
        // one random byte out, done flag timed in rollovers
        seed = xs(seed);
        txQ.push_back(nine ? {1'h1, c[CTRL_TX9], seed[7:0]}
                           : {2'h1, seed[7:0]});
        wr(OFS_DATA, seed[7:0]);
        t0 = $time;
        wr(OFS_DATA, ~seed[7:0]); // refused while busy
        s = 8'h00;
        for (int i = 0; i < 400 && !s[ST_TXD]; i++) rd(OFS_STATUS, s);
        el = int'(($time - t0) / 50) - (nine ? 10 : 9) * int'(bc);
        chk(10'(el > 0 && el <= int'(bc) + 4), 10'h001);
        expDone = 1;
        for (int i = 0; i < 4 * bc && i_uam_partner.gotQ.size() == 0; i++)
            @(posedge clk);
        chk(10'(i_uam_partner.gotQ.size()), 10'h001);
        if (i_uam_partner.gotQ.size() != 0)
            chk(i_uam_partner.gotQ.pop_front(), txQ.pop_front());
        chkStatus();
        wr(OFS_INT_CLR, 8'h02);
        expDone = 0;
        // false start, a good frame, then one dropped on a full buffer
        i_uam_partner.send(11'h000, 1, bc / 8);
        repeat (bc) @(posedge clk);
        seed = xs(seed);
        rxFrame(seed[7:0], 1'h1);
        seed = xs(seed);
        rxFrame(seed[7:0], seed[8]);
        wr(OFS_INT_EN, 8'h02);
        expEn = 2;
        chkStatus();
        wr(OFS_INT_CLR, 8'h01);
        wr(OFS_INT_EN, 8'h03);
        expFlag = 0;
        expEn = 3;
        // address filter: last bit zero dropped, last bit one kept
        mpf = 1;
        wr(OFS_CTRL, c | 8'h04);
        rxFrame(seed[15:8], 1'h0);
        rxFrame(seed[23:16], 1'h1);
        wr(OFS_INT_CLR, 8'h01);
        expFlag = 0;
        $display("mode test %0d finished", k);
    endtask : runMode
    task automatic closeOut;
        $display("checks %0d, mismatches %0d", checksDone, fails);
        if (fails == 0 && checksDone > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : closeOut
    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial
    begin
        {rst_n, regWr, regRd, timer1Roll, timer2Roll} = 5'h00;
        ce = 1'h1;
        regAddr = 3'h0;
        regWdata = 8'h00;
        {cyc, fails, checksDone, mpf} = '0;
        {expFlag, expDone, expNinth, expByte, expEn} = '0;
        seed = 32'h00015407;
        bc = 8'h20;
        nine = 1'h0;
        repeat (16) @(posedge clk);
        rst_n <= 1'h1;
        chk(10'(txPin), 10'h001);
        chkStatus();
        rd(3'h7, d);
        chk(10'(d), 10'h000);
        rd(OFS_INT_CLR, d);
        chk(10'(d), 10'h000);
        wr(OFS_INT_EN, 8'h03);
        expEn = 3;
        // a frozen engine must not take a write
        ce <= 1'h0;
        wr(OFS_INT_EN, 8'h00);
        ce <= 1'h1;
        rd(OFS_INT_EN, d);
        chk(10'(d), 10'h003);
        $display("register test finished");
        for (int k = 0; k < 4; k++) runMode(k);
        closeOut();
    end
endmodule : uam_core_tb
